//--- bench/sdpa_vme_master.sv
// Behavioural VME master driving the arbiter's slave pins.
// Assumes the bench resolves DTACK and the data bus from the enables.
`timescale 1ns/1ps
`default_nettype none
module sdpa_vme_master (
    // Clock
    input wire logic core_clk,
    // Master pins
    output logic as_n,
    output logic [1:0] ds_n,
    output logic lword_n,
    output logic write_n,
    output logic [31:0] addr,
    output logic [5:0] am,
    output logic [31:0] data,
    // Resolved slave answer
    input wire logic dtack_n,
    input wire logic [31:0] rdata
);
    // Idle bus at time zero
    initial begin
        as_n = 1'b1;
        ds_n = 2'h3;
        lword_n = 1'b1;
        write_n = 1'b1;
        addr = 32'h0;
        am = 6'h0;
        data = 32'h0;
    end

    // One D32 transfer; ado skips the data phase, k counts edges waited
    task automatic cycle(input logic [31:0] a, input logic [5:0] m, input logic wr,
            input logic ado, input logic [31:0] wd, output logic [31:0] rd, output int k);
        @(posedge core_clk);
        as_n <= 1'b0;
        addr <= a;
        am <= m;
        lword_n <= 1'b0;
        write_n <= ~wr;
        data <= wd;
        @(posedge core_clk);
        ds_n <= ado ? 2'h3 : 2'h0;
        k = 0;
        // Give up after 40 edges, as a bus timer would
        do begin
            @(posedge core_clk);
            k++;
        end while (dtack_n !== 1'b0 && k < 40);
        rd = rdata;
        ds_n <= 2'h3;
        as_n <= 1'b1;
        // Released lines must not keep looking valid
        addr <= ~a;
        data <= ~wd;
        repeat (2) @(posedge core_clk);
    endtask : cycle

    // RMW under one address strobe; lw and ds pick the lanes, k sums edges waited
    task automatic rmw(input logic [31:0] a, input logic [5:0] m, input logic lw,
            input logic [1:0] ds, input logic [31:0] wd, output logic [31:0] rd,
            output int k);
        @(posedge core_clk);
        as_n <= 1'b0;
        addr <= a;
        am <= m;
        lword_n <= lw;
        write_n <= 1'b1;
        @(posedge core_clk);
        ds_n <= ds;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (dtack_n !== 1'b0 && k < 40);
        rd = rdata;
        // Strobes up with address strobe held, then the write half
        ds_n <= 2'h3;
        write_n <= 1'b0;
        data <= wd;
        @(posedge core_clk);
        ds_n <= ds;
        do begin
            @(posedge core_clk);
            k++;
        end while (dtack_n !== 1'b0 && k < 80);
        ds_n <= 2'h3;
        as_n <= 1'b1;
        addr <= ~a;
        data <= ~wd;
        repeat (2) @(posedge core_clk);
    endtask : rmw
endmodule : sdpa_vme_master
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the shared RAM arbiter.
// Assumes the VME master model and the design's defines header.
`timescale 1ns/1ps
`default_nettype none
`include "sdpa_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cpu_req = 1'b0;
    logic cpu_we = 1'b0;
    logic [17:0] cpu_addr = 18'h0;
    logic [3:0] cpu_be = 4'hf;
    logic [31:0] cpu_wdata = 32'h0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cpu_ack, vme_data_oe, vme_dtack_out_n, vme_dtack_oe;
    logic [31:0] cpu_rdata, vme_data_out, reg_rdata, vme_addr, vme_data_in, d;
    logic vme_as_n, vme_lword_n, vme_write_n;
    logic [1:0] vme_ds_n;
    logic [5:0] vme_am;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    // Pulled-up DTACK and a shared data bus
    wire logic dtack_n = vme_dtack_oe ? vme_dtack_out_n : 1'b1;
    wire logic [31:0] vbus = vme_data_oe ? vme_data_out : vme_data_in;

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    sdpa_arbiter sdpa_arbiter_inst (.core_clk, .reset, .cpu_req, .cpu_we, .cpu_addr,
        .cpu_be, .cpu_wdata, .cpu_ack, .cpu_rdata, .vme_as_n, .vme_ds_n, .vme_lword_n,
        .vme_write_n, .vme_addr, .vme_am, .vme_data_in, .vme_data_out, .vme_data_oe,
        .vme_dtack_out_n, .vme_dtack_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);

    sdpa_vme_master sdpa_vme_master_inst (.core_clk(core_clk), .as_n(vme_as_n),
        .ds_n(vme_ds_n), .lword_n(vme_lword_n), .write_n(vme_write_n), .addr(vme_addr),
        .am(vme_am), .data(vme_data_in), .dtack_n(dtack_n), .rdata(vbus));

    task automatic report_and_stop;
        $display("compared %0d, mismatched %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // Cycle ceiling cuts a hung handshake short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_read

    task automatic cpu_op(input logic we, input logic [17:0] a, input logic [3:0] be,
            input logic [31:0] v, output logic [31:0] r);
        @(posedge core_clk);
        cpu_req <= 1'b1;
        cpu_we <= we;
        cpu_addr <= a;
        cpu_be <= be;
        cpu_wdata <= v;
        #1 `CHK(cpu_ack, 1'b1)
        @(posedge core_clk);
        cpu_req <= 1'b0;
        #1 r = cpu_rdata;
    endtask : cpu_op

    task automatic t_regs;
        reg_read(`SDPA_REG_CTRL, d);
        `CHK(d, 32'h0)
        reg_read(8'h14, d);
        `CHK(d, 32'h0)
        reg_write(`SDPA_REG_START, 32'h1000_0000);
        reg_write(`SDPA_REG_END, 32'h100f_f000);
        reg_write(`SDPA_REG_CTRL, 32'h0000_005d);
        reg_read(`SDPA_REG_START, d);
        `CHK(d, 32'h1000_0000)
        $display("test regs done");
    endtask : t_regs

    task automatic t_ports;
        cpu_op(1'b1, 18'h5, 4'hf, 32'hcafe_f00d, d);
        cpu_op(1'b1, 18'h5, 4'h1, 32'h0000_0011, d);
        cpu_op(1'b0, 18'h5, 4'hf, 32'h0, d);
        `CHK(d, 32'hcafe_f011)
        sdpa_vme_master_inst.cycle(32'h1000_0014, 6'h0d, 1'b0, 1'b0, 32'h0, d, n);
        `CHK(d, 32'hcafe_f011)
        `CHK(n <= 4, 1'b1)
        sdpa_vme_master_inst.cycle(32'h1000_0020, 6'h0d, 1'b1, 1'b0, 32'h1234_5678, d, n);
        sdpa_vme_master_inst.cycle(32'h100f_fffc, 6'h0e, 1'b1, 1'b0, 32'h0bad_cafe, d, n);
        sdpa_vme_master_inst.cycle(32'h1000_0014, 6'h09, 1'b0, 1'b0, 32'h0, d, n);
        `CHK(d, 32'hcafe_f011)
        cpu_op(1'b0, 18'h8, 4'hf, 32'h0, d);
        `CHK(d, 32'h1234_5678)
        cpu_op(1'b0, 18'h3ffff, 4'hf, 32'h0, d);
        `CHK(d, 32'h0bad_cafe)
        $display("test ports done");
    endtask : t_ports

    task automatic t_refuse;
        sdpa_vme_master_inst.cycle(32'h1010_0000, 6'h0d, 1'b0, 1'b0, 32'h0, d, n);
        `CHK(n, 40)
        sdpa_vme_master_inst.cycle(32'h1000_0014, 6'h2d, 1'b0, 1'b0, 32'h0, d, n);
        `CHK(n, 40)
        sdpa_vme_master_inst.cycle(32'h1000_0014, 6'h0d, 1'b0, 1'b1, 32'h0, d, n);
        `CHK(n, 40)
        // A clear in mid-violation must lose to the new violation
        fork
            sdpa_vme_master_inst.cycle(32'h1000_0014, 6'h09, 1'b1, 1'b0, 32'h0, d, n);
            begin
                repeat (8) @(posedge core_clk);
                reg_write(`SDPA_REG_STATUS, 32'h2);
            end
        join
        `CHK(n, 40)
        reg_read(`SDPA_REG_STATUS, d);
        `CHK(d & 32'h2, 32'h2)
        reg_write(`SDPA_REG_STATUS, 32'h2);
        reg_read(`SDPA_REG_STATUS, d);
        `CHK(d & 32'h2, 32'h0)
        cpu_op(1'b0, 18'h5, 4'hf, 32'h0, d);
        `CHK(d, 32'hcafe_f011)
        $display("test refuse done");
    endtask : t_refuse

    // CPU hogs every cycle; the VME read must wait for a free slot
    task automatic t_slot;
        fork
            begin
                repeat (20) begin
                    @(posedge core_clk);
                    cpu_req <= 1'b1;
                    #1 `CHK(cpu_ack, 1'b1)
                end
                @(posedge core_clk);
                cpu_req <= 1'b0;
            end
            sdpa_vme_master_inst.cycle(32'h1000_0014, 6'h0d, 1'b0, 1'b0, 32'h0, d, n);
        join
        `CHK(n >= 20 && n <= 24, 1'b1)
        `CHK(d, 32'hcafe_f011)
        $display("test slot done");
    endtask : t_slot

    // RMW on a D16 pair at an odd half-word; only the low lanes change
    task automatic t_rmw;
        sdpa_vme_master_inst.rmw(32'h1000_0022, 6'h0d, 1'b1, 2'h0, 32'h0000_beef, d, n);
        `CHK(d, 32'h1234_5678)
        `CHK(n <= 8, 1'b1)
        cpu_op(1'b0, 18'h8, 4'hf, 32'h0, d);
        `CHK(d, 32'h1234_beef)
        $display("test rmw done");
    endtask : t_rmw

    task automatic t_a24;
        reg_write(`SDPA_REG_START, 32'h0020_0000);
        reg_write(`SDPA_REG_END, 32'h0020_0000);
        reg_write(`SDPA_REG_CTRL, 32'h0000_005f);
        sdpa_vme_master_inst.cycle(32'hff20_0014, 6'h3d, 1'b0, 1'b0, 32'h0, d, n);
        `CHK(d, 32'hcafe_f011)
        reg_read(`SDPA_REG_COUNT, d);
        `CHK(d, 32'h8)
        $display("test a24 done");
    endtask : t_a24

    // Reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        t_regs();
        t_ports();
        t_refuse();
        t_slot();
        t_rmw();
        t_a24();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

//--- core/sdpa_arbiter.sv
// Shared dual port RAM arbiter: CPU port, VME slave port, registers.
// Assumes CPU and VME pins synchronous to core_clk; the DTACK and data
// pins are resolved outside from the enables.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdpa_defines.svh"
module sdpa_arbiter
    import sdpa_pkg::*;
#(
    parameter int RAM_ABITS = `SDPA_RAM_ABITS,
    parameter int VME_SLOT_GAP = `SDPA_VME_SLOT_GAP
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Local CPU port
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [RAM_ABITS-3:0] cpu_addr,
    input wire logic [3:0] cpu_be,
    input wire logic [31:0] cpu_wdata,
    output logic cpu_ack,
    output logic [31:0] cpu_rdata,
    // VME slave pins
    input wire logic vme_as_n,
    input wire logic [1:0] vme_ds_n,
    input wire logic vme_lword_n,
    input wire logic vme_write_n,
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic [31:0] vme_data_in,
    output logic [31:0] vme_data_out,
    output logic vme_data_oe,
    output logic vme_dtack_out_n,
    output logic vme_dtack_oe,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    localparam int PB = `SDPA_PAGE_BITS;

    // One megabyte of shared RAM as 32-bit words
    // No reset: contents survive a reset of the arbiter
    logic [31:0] mem [0:(1<<(RAM_ABITS-2))-1]; // [R4]

    sdpa_vstate_type state_q;
    logic [`SDPA_CTRL_W-1:0] ctrl_q;
    logic [31-PB:0] start_q;
    logic [31-PB:0] end_q;
    logic viol_q;
    logic [31:0] count_q;
    logic [31:0] addr_q;
    logic [5:0] am_q;
    logic write_q;
    logic [3:0] be_q;
    logic [31:0] wdata_q;
    logic [RAM_ABITS-3:0] idx_q;
    logic [7:0] gap_q;
    logic [31:0] cpu_rdata_q;
    logic [31:0] vme_rdata_q;
    logic [31:0] reg_rdata_q;
    logic hit;
    logic wprot;
    logic [RAM_ABITS-3:0] word_index;
    logic ds_any;
    logic accept;
    logic vme_slot;

    // VME byte lanes, big endian, lane 3 is the lowest byte address
    function automatic logic [3:0] vme_lanes(input logic lword_n,
                                             input logic a1,
                                             input logic [1:0] ds_n);
        logic [1:0] ds;
        ds = ~ds_n;
        if (!lword_n) begin
            // Quad and unaligned triple or middle pair
            if (a1) vme_lanes = (ds == 2'h3) ? 4'h6 : 4'h0;
            else if (ds == 2'h3) vme_lanes = 4'hf;
            else if (ds == 2'h2) vme_lanes = 4'he;
            else if (ds == 2'h1) vme_lanes = 4'h7;
            else vme_lanes = 4'h0;
        end else if (a1) begin
            vme_lanes = {2'h0, ds};
        end else begin
            vme_lanes = {ds, 2'h0};
        end
    endfunction : vme_lanes

    sdpa_window_decode sdpa_window_decode_inst (
        .addr(addr_q),
        .am(am_q),
        .write(!vme_write_n),
        .ctrl(ctrl_q),
        .start_page(start_q),
        .end_page(end_q),
        .hit(hit),
        .wprot(wprot),
        .word_index(word_index)
    );

    // Data strobe seen; lanes must form a legal width to be taken
    assign ds_any = (vme_ds_n != 2'h3);
    assign accept = hit && !wprot
        && (vme_lanes(vme_lword_n, addr_q[1], vme_ds_n) != 4'h0); // [R9] [R10]

    // The CPU always owns the RAM when it asks; VME fills gaps, rate capped
    // Trade-off: the fixed gap caps VME at its share at the cost of latency
    assign vme_slot = (state_q == V_WAIT) && !cpu_req // [R2]
        && (gap_q >= 8'(VME_SLOT_GAP - 1)); // [R3]

    // CPU never waits: acknowledge in the cycle of the request
    assign cpu_ack = cpu_req; // [R1]

    // VME slave cycle sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= V_IDLE;
        end else begin
            case (state_q)
                V_IDLE: if (!vme_as_n) state_q <= V_ADDR;
                // Address-only cycles end here without a strobe
                V_ADDR: begin
                    if (vme_as_n) state_q <= V_IDLE; // [R10]
                    else if (ds_any && accept) state_q <= V_WAIT; // [R6]
                end
                V_WAIT: if (vme_slot) state_q <= V_ACK;
                // RMW keeps AS low and strobes again from V_ADDR
                V_ACK: begin
                    if (!ds_any) state_q <= vme_as_n ? V_IDLE : V_ADDR; // [R10]
                end
                default: state_q <= V_IDLE;
            endcase
        end
    end

    // Address and modifier latched at address strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_q <= 32'h00000000;
            am_q <= 6'h00;
        end else if (state_q == V_IDLE && !vme_as_n) begin
            addr_q <= vme_addr;
            am_q <= vme_am;
        end
    end

    // Transfer details latched at data strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            write_q <= 1'b0;
            be_q <= 4'h0;
            wdata_q <= 32'h00000000;
            idx_q <= '0;
        end else if (state_q == V_ADDR && ds_any && accept) begin
            write_q <= !vme_write_n;
            be_q <= vme_lanes(vme_lword_n, addr_q[1], vme_ds_n);
            wdata_q <= vme_data_in;
            idx_q <= word_index;
        end
    end

    // Spacing counter since the last VME slot, saturating
    // Starts saturated so the first VME cycle after reset is not held back
    always_ff @(posedge core_clk) begin
        if (reset) gap_q <= 8'hff;
        else if (vme_slot) gap_q <= 8'h00;
        else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end

    // RAM writes: CPU first, VME only in its slot
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (cpu_req && cpu_we && cpu_be[i]) begin
                mem[cpu_addr][i*8 +: 8] <= cpu_wdata[i*8 +: 8]; // [R1]
            end else if (vme_slot && write_q && be_q[i]) begin
                mem[idx_q][i*8 +: 8] <= wdata_q[i*8 +: 8]; // [R2]
            end
        end
    end

    // RAM reads, data one cycle after the access
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpu_rdata_q <= 32'h00000000;
            vme_rdata_q <= 32'h00000000;
        end else begin
            if (cpu_req && !cpu_we) cpu_rdata_q <= mem[cpu_addr];
            if (vme_slot && !write_q) vme_rdata_q <= mem[idx_q];
        end
    end

    // Pin drive: DTACK only after the slot has completed
    // Limitation: no bus error; a refused cycle runs into the master's bus timer
    assign cpu_rdata = cpu_rdata_q;
    assign vme_dtack_out_n = (state_q != V_ACK); // [R11]
    assign vme_dtack_oe = (state_q == V_ACK);
    assign vme_data_out = vme_rdata_q;
    assign vme_data_oe = (state_q == V_ACK) && !write_q;

    // Control and window registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q <= `SDPA_CTRL_RST;
            start_q <= `SDPA_PAGE_RST;
            end_q <= `SDPA_PAGE_RST;
        end else if (reg_wr) begin
            if (reg_addr == `SDPA_REG_CTRL) ctrl_q <= reg_wdata[`SDPA_CTRL_W-1:0];
            else if (reg_addr == `SDPA_REG_START) start_q <= reg_wdata[31:PB]; // [R5] [R7]
            else if (reg_addr == `SDPA_REG_END) end_q <= reg_wdata[31:PB]; // [R7]
        end
    end

    // Protection violation, sticky; a new one wins over the clear
    always_ff @(posedge core_clk) begin
        if (reset) viol_q <= 1'b0;
        else if (state_q == V_ADDR && ds_any && hit && wprot) viol_q <= 1'b1; // [R8]
        else if (reg_wr && reg_addr == `SDPA_REG_STATUS
                 && reg_wdata[`SDPA_STAT_VIOL]) viol_q <= 1'b0;
    end

    // Completed VME slots, wraps
    always_ff @(posedge core_clk) begin
        if (reset) count_q <= 32'h00000000;
        else if (vme_slot) count_q <= count_q + 32'h00000001;
    end

    // Register read, data in the following cycle; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `SDPA_REG_CTRL) reg_rdata_q <= {25'h0, ctrl_q};
            else if (reg_addr == `SDPA_REG_START) reg_rdata_q <= {start_q, 12'h000};
            else if (reg_addr == `SDPA_REG_END) reg_rdata_q <= {end_q, 12'h000};
            else if (reg_addr == `SDPA_REG_STATUS)
                reg_rdata_q <= {30'h0, viol_q, state_q != V_IDLE};
            else if (reg_addr == `SDPA_REG_COUNT) reg_rdata_q <= count_q;
            else reg_rdata_q <= 32'h00000000;
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // Checks on the arbitration and slave cycle
    cpu_zero_wait_a: assert property (@(posedge core_clk) disable iff (reset) // [R1]
        cpu_req |-> cpu_ack)
        else $error("CPU request not acknowledged at once");
    vme_gap_only_a: assert property (@(posedge core_clk) disable iff (reset) // [R2]
        vme_slot |-> !cpu_req)
        else $error("VME slot taken during CPU access");
    slot_spacing_a: assert property (@(posedge core_clk) disable iff (reset) // [R3]
        vme_slot |=> !vme_slot ##1 !vme_slot)
        else $error("VME slots closer than the bandwidth cap");
    window_hit_a: assert property (@(posedge core_clk) disable iff (reset) // [R7]
        (state_q == V_ADDR && ds_any && !hit) |=> state_q != V_WAIT)
        else $error("Access outside window was taken");
    am_decode_a: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        $rose(state_q == V_WAIT) |-> $past(hit))
        else $error("Cycle taken without address and modifier match");
    write_protect_a: assert property (@(posedge core_clk) disable iff (reset) // [R8]
        (state_q == V_ADDR && ds_any && hit && wprot) |=> viol_q && state_q != V_WAIT)
        else $error("Protected write was not refused");
    addr_only_a: assert property (@(posedge core_clk) disable iff (reset) // [R10]
        (state_q == V_ADDR && !ds_any) |=> vme_dtack_out_n)
        else $error("DTACK on an address-only cycle");
    dtack_after_slot_a: assert property (@(posedge core_clk) disable iff (reset) // [R11]
        $fell(vme_dtack_out_n) |-> $past(vme_slot))
        else $error("DTACK without a completed RAM slot");
    dtack_release_a: assert property (@(posedge core_clk) disable iff (reset) // [R9]
        (state_q == V_ACK && !ds_any) |=> vme_dtack_out_n && !vme_data_oe)
        else $error("DTACK or data held after strobes released");

    // Handshake holding, RMW re-entry and flag priority
    vme_waits_cpu_a: assert property (@(posedge core_clk) disable iff (reset) // [R2]
        (state_q == V_WAIT && cpu_req) |=> state_q == V_WAIT)
        else $error("VME slot granted over a CPU access");
    dtack_stands_a: assert property (@(posedge core_clk) disable iff (reset) // [R11]
        (state_q == V_ACK && ds_any) |=> !vme_dtack_out_n)
        else $error("DTACK dropped while strobes still low");
    read_data_stands_a: assert property (@(posedge core_clk) disable iff (reset) // [R11]
        (state_q == V_ACK && $past(state_q) == V_ACK) |-> $stable(vme_data_out))
        else $error("Read data changed while DTACK stands");
    rmw_readdress_a: assert property (@(posedge core_clk) disable iff (reset) // [R10]
        (state_q == V_ACK && !ds_any && !vme_as_n) |=> state_q == V_ADDR)
        else $error("RMW second strobe not awaited");
    addr_only_end_a: assert property (@(posedge core_clk) disable iff (reset) // [R10]
        (state_q == V_ADDR && vme_as_n) |=> state_q == V_IDLE)
        else $error("Cycle not ended by address strobe release");
    refused_hold_a: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        (state_q == V_ADDR && ds_any && !accept && !vme_as_n) |=> state_q == V_ADDR)
        else $error("Refused VME cycle left the address phase");
    viol_set_wins_a: assert property (@(posedge core_clk) disable iff (reset) // [R8]
        (state_q == V_ADDR && ds_any && hit && wprot && reg_wr
            && reg_addr == `SDPA_REG_STATUS && reg_wdata[`SDPA_STAT_VIOL]) |=> viol_q)
        else $error("Violation lost to a clear in the same cycle");
endmodule : sdpa_arbiter
`default_nettype wire

//--- core/sdpa_defines.svh
// Constants for the shared dual port RAM arbiter: register offsets,
// field positions, reset values and slot timing.
// Assumes inclusion by bare name from every file that needs them.
// Functional notes
// R1 - CPU RAM accesses served at once, zero wait
// R2 - VME accesses only in free CPU slots
// R3 - VME bandwidth half of local CPU share
// R4 - One megabyte shared RAM for both ports
// R5 - VME window placeable anywhere in 4 GB
// R6 - Decode VME address and modifier before accepting
// R7 - Window start and end in 4K steps
// R8 - Write protection chosen per modifier class
// R9 - Accept A32/A24 with D8, D16, D32 only
// R10 - Unaligned, address-only and RMW cycles supported
// R11 - Hold DTACK until granted slot completes
`ifndef SDPA_DEFINES_SVH
`define SDPA_DEFINES_SVH

// Register byte offsets
`define SDPA_REG_CTRL 8'h00
`define SDPA_REG_START 8'h04
`define SDPA_REG_END 8'h08
`define SDPA_REG_STATUS 8'h0c
`define SDPA_REG_COUNT 8'h10

// Control field positions
`define SDPA_CTRL_EN 0
`define SDPA_CTRL_A24 1
`define SDPA_CTRL_A32 2
`define SDPA_CTRL_SUP 3
`define SDPA_CTRL_USR 4
`define SDPA_CTRL_WP_SUP 5
`define SDPA_CTRL_WP_USR 6
`define SDPA_CTRL_W 7

// Status field positions
`define SDPA_STAT_BUSY 0
`define SDPA_STAT_VIOL 1

// Reset values
`define SDPA_CTRL_RST 7'h00
`define SDPA_PAGE_RST 20'h00000

// Window granularity and RAM size in address bits
`define SDPA_PAGE_BITS 12
`define SDPA_RAM_ABITS 20

// Least cycles between two VME slots: one VME slot per two CPU slots
`define SDPA_VME_SLOT_GAP 3

`endif

//--- core/sdpa_pkg.sv
// Types shared by the shared RAM arbiter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sdpa_pkg;
    // VME slave cycle states
    typedef enum logic [1:0] {
        V_IDLE,
        V_ADDR,
        V_WAIT,
        V_ACK
    } sdpa_vstate_type;

    // Privilege class of an address modifier
    typedef enum logic [1:0] {
        AMC_NONE,
        AMC_USER,
        AMC_SUPER
    } sdpa_amclass_type;
endpackage : sdpa_pkg

//--- core/sdpa_window_decode.sv
// VME slave window decoder: address range, modifier class, protection.
// Assumes latched address and modifier, and control fields from registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdpa_defines.svh"
module sdpa_window_decode
    import sdpa_pkg::*;
(
    // Latched VME address and modifier, live write line
    input wire logic [31:0] addr,
    input wire logic [5:0] am,
    input wire logic write,
    // Window settings
    input wire logic [`SDPA_CTRL_W-1:0] ctrl,
    input wire logic [31-`SDPA_PAGE_BITS:0] start_page,
    input wire logic [31-`SDPA_PAGE_BITS:0] end_page,
    // Result
    output logic hit,
    output logic wprot,
    output logic [`SDPA_RAM_ABITS-3:0] word_index
);
    sdpa_amclass_type cls;
    logic a32;
    logic [31:0] eff;
    logic [31:0] diff;

    // Block transfer and short modifiers fall in AMC_NONE and are ignored
    function automatic sdpa_amclass_type am_class(input logic [5:0] code);
        case (code)
            6'h09, 6'h0a, 6'h39, 6'h3a: am_class = AMC_USER;
            6'h0d, 6'h0e, 6'h3d, 6'h3e: am_class = AMC_SUPER;
            default: am_class = AMC_NONE;
        endcase
    endfunction : am_class

    // Modifier class and address width
    always_comb begin
        cls = am_class(am);
        a32 = (am[5:4] == 2'h0);
        // A24 addresses are compared with the upper byte zero
        eff = a32 ? addr : {8'h00, addr[23:0]};
        diff = eff - {start_page, 12'h000};
    end

    // Range and modifier must both match before the cycle is taken
    always_comb begin
        hit = ctrl[`SDPA_CTRL_EN]
            && (cls != AMC_NONE) // [R6]
            && (a32 ? ctrl[`SDPA_CTRL_A32] : ctrl[`SDPA_CTRL_A24]) // [R9]
            && (cls == AMC_SUPER ? ctrl[`SDPA_CTRL_SUP] : ctrl[`SDPA_CTRL_USR])
            && (eff[31:`SDPA_PAGE_BITS] >= start_page) // [R7]
            && (eff[31:`SDPA_PAGE_BITS] <= end_page); // [R5] [R7]
        wprot = write && (cls == AMC_SUPER ? ctrl[`SDPA_CTRL_WP_SUP]
                                           : ctrl[`SDPA_CTRL_WP_USR]); // [R8]
        // Windows larger than the RAM wrap onto it
        word_index = diff[`SDPA_RAM_ABITS-1:2];
    end
endmodule : sdpa_window_decode
`default_nettype wire
